// ### test_task_file_address_decoder.sv
// Purpose: Self-checking bench for the task file decoder.
// Assumes: Model read words are {~n, n}, n counting from 0.
// Notes:   Memory strobes in socket memory mode, I/O strobes in socket I/O and disk modes.
`timescale 1ns/1ps
module test_task_file_address_decoder;
    logic clk_i = 0, rst_n_i = 0, disk_mode_i = 0, byte_mode_i = 0;
    logic [10:0] addr_i = 0;
    logic [15:0] data_i = 0, data_o, rd_data_i, wr_data_o, rd;
    logic [7:0]  cnt, op, opt, hc;
    logic [1:0]  oe, ln;
    logic io_mode_i = 0, ack;
    logic rd_valid_i, rd_ready_o, wr_valid_o, wr_ready_i, stall = 0;
    logic mem_read_strobe_n_i = 1, mem_write_strobe_n_i = 1;
    logic io_read_strobe_n_i = 1, io_write_strobe_n_i = 1;
    logic task_file_select_n_i = 1, control_block_select_n_i = 1;
    logic low_byte_enable_n_i = 1, high_byte_enable_n_i = 1;
    int   errors = 0, check_count = 0;
    always #4 clk_i = ~clk_i;
    tfd_decoder i_tfd_decoder (.clk_i, .rst_n_i, .disk_mode_i,
        .io_mode_i, .common_sel_i(1'b1), .addr_i, .low_byte_enable_n_i,
        .high_byte_enable_n_i, .mem_read_strobe_n_i, .mem_write_strobe_n_i,
        .io_read_strobe_n_i, .io_write_strobe_n_i, .task_file_select_n_i,
        .control_block_select_n_i, .data_i, .data_o, .data_oe_o(oe),
        .wide_io_ack_n_o(ack), .byte_mode_i, .fault_info_i(8'h5A),
        .state_flags_i(8'h50), .unit_address_i(8'h3C), .rd_valid_i,
        .rd_data_i, .rd_ready_o, .wr_valid_o, .wr_data_o, .wr_ready_i,
        .transfer_block_count_o(cnt), .start_block_low_o(),
        .start_block_mid_o(), .start_block_high_o(), .unit_and_top_bits_o(),
        .option_select_o(opt), .op_issue_o(op), .op_valid_o(),
        .host_control_o(hc));
    tfd_core_model i_tfd_core_model (.clk_i, .rst_n_i, .stall_i(stall),
        .rd_ready_i(rd_ready_o), .rd_valid_o(rd_valid_i),
        .rd_data_o(rd_data_i), .wr_valid_i(wr_valid_o),
        .wr_data_i(wr_data_o), .wr_ready_o(wr_ready_i));
    task automatic chk(input logic [15:0] s, e);
        check_count++;
        if (s !== e) errors++;
        if (s !== e) $display("ERROR t=%0t seen %h exp %h", $time, s, e);
    endtask
    // One strobe per access; read data is taken just before release
    task automatic acc(input logic w, input logic [10:0] a,
                       input logic [1:0] b, input logic [15:0] d);
        @(negedge clk_i);
        {addr_i, data_i} = {a, d};
        {high_byte_enable_n_i, low_byte_enable_n_i} = b;
        if (disk_mode_i || io_mode_i)
            {io_write_strobe_n_i, io_read_strobe_n_i} = {!w, w};
        else {mem_write_strobe_n_i, mem_read_strobe_n_i} = {!w, w};
        repeat (2) @(negedge clk_i);
        {ln, rd} = {oe, data_o};
        {mem_write_strobe_n_i, mem_read_strobe_n_i} = 2'b11;
        {io_write_strobe_n_i, io_read_strobe_n_i} = 2'b11;
        repeat (2) @(negedge clk_i);
    endtask
    task automatic rc(input logic [10:0] a, input logic [1:0] b,
                      input logic [15:0] e);
        acc(0, a, b, 16'h0000);
        chk(rd & {{8{!b[1]}}, {8{!b[0]}}}, e);
        chk(ln, {14'h0, ~b});
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (12) @(negedge clk_i);
        rst_n_i = 1;
        chk(cnt, 16'h0000);
        acc(1, 11'h002, 2'b10, 16'h00A5);
        chk(cnt, 16'h00A5);
        acc(1, 11'h007, 2'b10, 16'h0037);
        chk(op, 16'h0037);
        rc(11'h3F2, 2'b10, 16'h00A5);
        rc(11'h00E, 2'b10, 16'h0050);
        $display("register test done");
        rc(11'h000, 2'b00, 16'hFF00);
        rc(11'h008, 2'b00, 16'hFE01);
        rc(11'h001, 2'b00, 16'hFD02);
        rc(11'h000, 2'b10, 16'h0003);
        rc(11'h000, 2'b10, 16'h00FC);
        rc(11'h009, 2'b10, 16'h00FB);
        rc(11'h008, 2'b10, 16'h0004);
        rc(11'h400, 2'b10, 16'h0005);
        rc(11'h7FF, 2'b10, 16'h00FA);
        rc(11'h5A5, 2'b00, 16'hF906);
        rc(11'h008, 2'b01, 16'hF800);
        rc(11'h000, 2'b10, 16'h0007);
        $display("data read test done");
        rc(11'h000, 2'b01, 16'h5A00);
        rc(11'h00D, 2'b10, 16'h005A);
        acc(1, 11'h000, 2'b01, 16'h3300);
        chk(opt, 16'h0033);
        acc(1, 11'h00F, 2'b10, 16'h00EE);
        chk({cnt, op}, 16'hA537);
        stall = 1;
        acc(1, 11'h000, 2'b00, 16'h1234);
        acc(1, 11'h402, 2'b00, 16'h5678);
        stall = 0;
        repeat (6) @(negedge clk_i);
        chk(i_tfd_core_model.wq[0], 16'h1234);
        chk(i_tfd_core_model.wq[1], 16'h5678);
        $display("write test done");
        io_mode_i = 1;
        acc(1, 11'h008, 2'b00, 16'h0000);
        chk(ack, 16'h0000);
        acc(0, 11'h002, 2'b01, 16'h0000);
        chk({ack, ln}, 16'h0004);
        {disk_mode_i, task_file_select_n_i} = 2'b10;
        acc(1, 11'h002, 2'b10, 16'h0042);
        chk(cnt, 16'h0042);
        rc(11'h000, 2'b00, 16'hF708);
        byte_mode_i = 1;
        rc(11'h000, 2'b10, 16'h0009);
        rc(11'h000, 2'b10, 16'h00F6);
        {task_file_select_n_i, control_block_select_n_i} = 2'b10;
        rc(11'h006, 2'b10, 16'h0050);
        acc(1, 11'h006, 2'b10, 16'h0004);
        chk(hc, 16'h0004);
        $display("disk mode test done");
        close_out;
    end
endmodule

// ### tfd_core_model.sv
// Purpose: Core side model: read word source and write word sink.
// Assumes: Words move on a rising edge with valid and ready high.
// Notes:   Read words are {~n, n}; stall_i holds both streams off.
`timescale 1ns/1ps
module tfd_core_model (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        stall_i,
    input  wire logic        rd_ready_i,
    output logic             rd_valid_o,
    output logic      [15:0] rd_data_o,
    input  wire logic        wr_valid_i,
    input  wire logic [15:0] wr_data_i,
    output logic             wr_ready_o
);
    logic [7:0]  n;
    logic [15:0] wq[$];
    // Bytes differ so lane swaps show; idle data is scrambled
    assign rd_data_o  = rd_valid_o ? {~n, n} : {n, ~n};
    assign rd_valid_o = rst_n_i && !stall_i;
    assign wr_ready_o = !stall_i;
    always @(posedge clk_i) begin
        if (!rst_n_i) n <= 8'h00;
        else if (rd_valid_o && rd_ready_i) n <= n + 8'h01;
        if (wr_valid_i && wr_ready_o && rst_n_i) wq.push_back(wr_data_i);
    end
endmodule

// ### tfd_decoder.sv
// Purpose: Task file address and byte-lane decoder with data FIFO port.
// Assumes: Host pins already synchronous to clk_i; one access per strobe.
// Notes:   Socket memory, socket I/O and disk-interface modes.
// Functional notes
// RL1 - Common memory window of 2K holds the task file; A9-A4 ignored.
// RL2 - A3-A0 select data, error, count, block, unit, status, mirror, address.
// RL3 - Word access at offset 0 uses D15-D0; byte pair gives even then odd.
// RL4 - Offset 0 with only high enable reaches error on read, option on write.
// RL5 - Offsets 8, 9, D duplicate 0 and 1; 9 then 8 gives odd then even.
// RL6 - Repeated byte or word accesses step through buffer bytes or words.
// RL7 - Host never repeats byte accesses to offset 9; it yields odd byte only.
// RL8 - Memory addresses 400h-7FFh map even to offset 8, odd to offset 9.
// RL9 - Whole 1K window is a sequential FIFO port; address picks no location.
// RL10 - Word at offset 8 gives even data low lane, odd data high lane.
// RL11 - Disk mode: task select decodes A2-A0; control select 110 is mirror.
// RL12 - Odd registers also at even address on D15-D8, except narrow I/O.
// RL13 - Disk mode width set by register; data 16-bit unless byte mode chosen.
// RL14 - Data register runs 8 bits during parts of long sector commands.
// RL15 - A 16-bit data register moves buffer blocks, overlapping error.
// RL16 - Socket word access at offset 1 goes to the word data register.
// RL17 - Duplicates at 8, 9, D take every access type the socket makes; the code ignores a high-byte-only access at D.
// RL18 - Odd data on D15-D8 at 8/9; error low at 1/D, high on D word.
// RL19 - Writes to reserved offset F change nothing.
`timescale 1ns/1ps
module tfd_decoder #(
    parameter int DATA_W = tfd_pkg::TFD_DW
) (
    input  wire logic        clk_i,
    input  wire logic        rst_n_i,
    input  wire logic        disk_mode_i,
    input  wire logic        io_mode_i,
    input  wire logic        common_sel_i,
    input  wire logic [10:0] addr_i,
    input  wire logic        low_byte_enable_n_i,
    input  wire logic        high_byte_enable_n_i,
    input  wire logic        mem_read_strobe_n_i,
    input  wire logic        mem_write_strobe_n_i,
    input  wire logic        io_read_strobe_n_i,
    input  wire logic        io_write_strobe_n_i,
    input  wire logic        task_file_select_n_i,
    input  wire logic        control_block_select_n_i,
    input  wire logic [15:0] data_i,
    output logic      [15:0] data_o,
    output logic      [1:0]  data_oe_o,
    output logic             wide_io_ack_n_o,
    input  wire logic        byte_mode_i,
    input  wire logic [7:0]  fault_info_i,
    input  wire logic [7:0]  state_flags_i,
    input  wire logic [7:0]  unit_address_i,
    input  wire logic        rd_valid_i,
    input  wire logic [15:0] rd_data_i,
    output logic             rd_ready_o,
    output logic             wr_valid_o,
    output logic      [15:0] wr_data_o,
    input  wire logic        wr_ready_i,
    output logic      [7:0]  transfer_block_count_o,
    output logic      [7:0]  start_block_low_o,
    output logic      [7:0]  start_block_mid_o,
    output logic      [7:0]  start_block_high_o,
    output logic      [7:0]  unit_and_top_bits_o,
    output logic      [7:0]  option_select_o,
    output logic      [7:0]  op_issue_o,
    output logic             op_valid_o,
    output logic      [7:0]  host_control_o
);
    if (DATA_W != tfd_pkg::TFD_DW) begin : g_chk
        $error("tfd_decoder: only a 16-bit host data bus is served");
    end

    tfd_pkg::tfd_state_t s;
    tfd_pkg::tfd_state_t next_s;
    tfd_pkg::tfd_kind_t  kind;

    logic [3:0] off;
    logic [3:0] roff;
    logic [7:0] regv;
    logic [1:0] hv;
    logic       io_cyc;
    logic       w;
    logic       bl;
    logic       bh;
    logic       rs;
    logic       ws;
    logic       sel;
    logic       is_dat;
    logic       start;

    tfd_stream_if #(.W(16)) rd_in_if ();
    tfd_stream_if #(.W(16)) rd_if ();
    tfd_stream_if #(.W(16)) wr_if ();
    tfd_stream_if #(.W(16)) wr_out_if ();

    // Read side: core feeds the buffer, host accesses drain it
    assign rd_in_if.valid = rd_valid_i;
    assign rd_in_if.data  = rd_data_i;
    assign rd_ready_o     = rd_in_if.ready;
    assign rd_if.ready    = s.pop;

    tfd_skid_buf #(.W(16)) u_rd_buf (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .up      (rd_in_if),
        .dn      (rd_if)
    );

    // Write side: assembled host words fill the buffer, core drains it
    assign wr_if.valid     = s.push;
    assign wr_if.data      = s.wbuf;
    assign wr_valid_o      = wr_out_if.valid;
    assign wr_data_o       = wr_out_if.data;
    assign wr_out_if.ready = wr_ready_i;

    tfd_skid_buf #(.W(16)) u_wr_buf (
        .clk_i   (clk_i),
        .rst_n_i (rst_n_i),
        .up      (wr_if),
        .dn      (wr_out_if)
    );

    assign data_o                 = s.dout;
    assign data_oe_o              = s.doe;
    assign wide_io_ack_n_o        = s.ack_n;
    assign transfer_block_count_o = s.transfer_block_count;
    assign start_block_low_o      = s.start_block_low;
    assign start_block_mid_o      = s.start_block_mid;
    assign start_block_high_o     = s.start_block_high;
    assign unit_and_top_bits_o    = s.unit_and_top_bits;
    assign option_select_o        = s.option_select;
    assign op_issue_o             = s.op_issue;
    assign op_valid_o             = s.op_valid;
    assign host_control_o         = s.host_control;

    always_comb begin
        next_s          = s;
        next_s.push     = 1'b0;
        next_s.pop      = 1'b0;
        next_s.op_valid = 1'b0;
        kind   = tfd_pkg::K_NONE;
        io_cyc = !disk_mode_i && io_mode_i;
        w      = !low_byte_enable_n_i && !high_byte_enable_n_i;
        bl     = !low_byte_enable_n_i && high_byte_enable_n_i;
        bh     = low_byte_enable_n_i && !high_byte_enable_n_i;
        if (disk_mode_i || io_mode_i) begin
            rs = !io_read_strobe_n_i;
            ws = !io_write_strobe_n_i;
        end else begin
            rs = !mem_read_strobe_n_i;
            ws = !mem_write_strobe_n_i;
        end
        if (disk_mode_i) begin
            // see RL11
            sel = (!task_file_select_n_i && control_block_select_n_i) ||
                  (!control_block_select_n_i && task_file_select_n_i &&
                   addr_i[2:0] == tfd_pkg::CTL_SUB);
            off = !task_file_select_n_i ? {1'b0, addr_i[2:0]}
                                        : tfd_pkg::OFF_MIRROR;
        end else if (io_mode_i) begin
            sel = 1'b1;
            off = addr_i[3:0];
        end else begin
            // Upper half is one FIFO port; only A0 survives, see RL8 RL9
            sel = common_sel_i;
            off = addr_i[tfd_pkg::WIN_BIT]
                ? (tfd_pkg::OFF_EVEN_COPY | {3'h0, addr_i[0]})
                : addr_i[3:0]; // see RL1
        end
        roff   = off;
        hv     = rs ? s.rh : s.wh;
        is_dat = off == tfd_pkg::OFF_DATA_PORT ||
                 off == tfd_pkg::OFF_EVEN_COPY ||
                 off == tfd_pkg::OFF_ODD_COPY;

        if (disk_mode_i) begin
            if (off == tfd_pkg::OFF_DATA_PORT) begin
                // Byte mode alternates even/odd on the low lane, see RL13 RL14
                kind = byte_mode_i ? (hv[0] ? tfd_pkg::K_ODD_LO
                                            : tfd_pkg::K_EVEN_LO)
                                   : tfd_pkg::K_WORD;
            end else begin
                kind = tfd_pkg::K_REG_LO;
            end
        end else if (w && (is_dat || off == tfd_pkg::OFF_FAULT_INFO)) begin
            kind = tfd_pkg::K_WORD; // see RL3 RL15 RL16 RL17
        end else if (w && off == tfd_pkg::OFF_FAULT_COPY) begin
            kind = tfd_pkg::K_REG_HI; // see RL18
            roff = tfd_pkg::OFF_FAULT_INFO;
        end else if (bl && (off == tfd_pkg::OFF_DATA_PORT ||
                            off == tfd_pkg::OFF_EVEN_COPY)) begin
            // Second byte of a pair takes the odd half, see RL3 RL6
            kind = hv[0] ? tfd_pkg::K_ODD_LO
                         : tfd_pkg::K_EVEN_LO; // see RL5
        end else if (bl && off == tfd_pkg::OFF_ODD_COPY) begin
            kind = tfd_pkg::K_ODD_LO; // see RL5 RL7
        end else if (bh && (off == tfd_pkg::OFF_EVEN_COPY ||
                            off == tfd_pkg::OFF_ODD_COPY)) begin
            kind = tfd_pkg::K_ODD_HI; // see RL18
        end else if (bl && off == tfd_pkg::OFF_FAULT_COPY) begin
            kind = tfd_pkg::K_REG_LO; // see RL18
            roff = tfd_pkg::OFF_FAULT_INFO;
        end else if (bh && !off[0] &&
                     (off < tfd_pkg::OFF_EVEN_COPY ||
                      off == tfd_pkg::OFF_MIRROR) &&
                     (off == tfd_pkg::OFF_DATA_PORT || !io_cyc)) begin
            // Odd register at even address on the high lane, see RL4 RL12
            kind = tfd_pkg::K_REG_HI;
            roff = off | 4'h1;
        end else if ((bl || w) && (off < tfd_pkg::OFF_EVEN_COPY ||
                                   off >= tfd_pkg::OFF_MIRROR)) begin
            kind = tfd_pkg::K_REG_LO; // see RL2
        end

        if (roff == tfd_pkg::OFF_FAULT_INFO) begin
            regv = fault_info_i;
        end else if (roff == tfd_pkg::OFF_BLOCK_COUNT) begin
            regv = s.transfer_block_count;
        end else if (roff == tfd_pkg::OFF_START_LOW) begin
            regv = s.start_block_low;
        end else if (roff == tfd_pkg::OFF_START_MID) begin
            regv = s.start_block_mid;
        end else if (roff == tfd_pkg::OFF_START_HIGH) begin
            regv = s.start_block_high;
        end else if (roff == tfd_pkg::OFF_UNIT_BITS) begin
            regv = s.unit_and_top_bits;
        end else if (roff == tfd_pkg::OFF_STATE_FLAGS ||
                     roff == tfd_pkg::OFF_MIRROR) begin
            regv = state_flags_i;
        end else if (roff == tfd_pkg::OFF_UNIT_ADDR) begin
            regv = unit_address_i;
        end else begin
            regv = 8'h00;
        end

        start       = sel && (rs || ws) && !s.act &&
                      kind != tfd_pkg::K_NONE;
        next_s.act  = rs || ws;
        next_s.ack_n = !(io_cyc && is_dat);
        if (!rs) begin
            next_s.doe = 2'b00;
        end

        if (start && rs) begin
            next_s.dout = 16'h0000;
            case (kind)
                tfd_pkg::K_WORD: begin
                    next_s.doe = 2'b11;
                    if (rd_if.valid) begin
                        next_s.dout = rd_if.data; // see RL10
                        next_s.rh   = 2'b11;
                    end
                end
                tfd_pkg::K_EVEN_LO: begin
                    next_s.doe = 2'b01;
                    if (rd_if.valid) begin
                        next_s.dout  = {8'h00, rd_if.data[7:0]};
                        next_s.rh[0] = 1'b1;
                    end
                end
                tfd_pkg::K_ODD_LO: begin
                    next_s.doe = 2'b01;
                    if (rd_if.valid) begin
                        next_s.dout  = {8'h00, rd_if.data[15:8]};
                        next_s.rh[1] = 1'b1;
                    end
                end
                tfd_pkg::K_ODD_HI: begin
                    next_s.doe = 2'b10;
                    if (rd_if.valid) begin
                        next_s.dout  = {rd_if.data[15:8], 8'h00};
                        next_s.rh[1] = 1'b1;
                    end
                end
                tfd_pkg::K_REG_LO: begin
                    next_s.doe  = 2'b01;
                    next_s.dout = {8'h00, regv};
                end
                tfd_pkg::K_REG_HI: begin
                    next_s.doe  = 2'b10;
                    next_s.dout = {regv, 8'h00};
                end
                default: begin
                    next_s.doe = 2'b00;
                end
            endcase
            // Word leaves the buffer once both halves were read, see RL6
            if (&next_s.rh) begin
                next_s.pop = 1'b1;
                next_s.rh  = 2'b00;
            end
        end

        if (start && ws) begin
            case (kind)
                tfd_pkg::K_WORD: begin
                    next_s.wbuf = data_i;
                    next_s.wh   = 2'b11;
                end
                tfd_pkg::K_EVEN_LO: begin
                    next_s.wbuf[7:0] = data_i[7:0];
                    next_s.wh[0]     = 1'b1;
                end
                tfd_pkg::K_ODD_LO: begin
                    next_s.wbuf[15:8] = data_i[7:0];
                    next_s.wh[1]      = 1'b1;
                end
                tfd_pkg::K_ODD_HI: begin
                    next_s.wbuf[15:8] = data_i[15:8];
                    next_s.wh[1]      = 1'b1;
                end
                default: begin
                    next_s.wh = s.wh;
                end
            endcase
            if (kind == tfd_pkg::K_REG_LO || kind == tfd_pkg::K_REG_HI) begin
                if (roff == tfd_pkg::OFF_FAULT_INFO) begin
                    next_s.option_select = kind == tfd_pkg::K_REG_HI
                                         ? data_i[15:8] : data_i[7:0];
                end else if (roff == tfd_pkg::OFF_BLOCK_COUNT) begin
                    next_s.transfer_block_count = kind == tfd_pkg::K_REG_HI
                                                ? data_i[15:8] : data_i[7:0];
                end else if (roff == tfd_pkg::OFF_START_LOW) begin
                    next_s.start_block_low = kind == tfd_pkg::K_REG_HI
                                           ? data_i[15:8] : data_i[7:0];
                end else if (roff == tfd_pkg::OFF_START_MID) begin
                    next_s.start_block_mid = data_i[7:0];
                end else if (roff == tfd_pkg::OFF_START_HIGH) begin
                    next_s.start_block_high = kind == tfd_pkg::K_REG_HI
                                            ? data_i[15:8] : data_i[7:0];
                end else if (roff == tfd_pkg::OFF_UNIT_BITS) begin
                    next_s.unit_and_top_bits = data_i[7:0];
                end else if (roff == tfd_pkg::OFF_STATE_FLAGS) begin
                    next_s.op_issue = kind == tfd_pkg::K_REG_HI
                                    ? data_i[15:8] : data_i[7:0];
                    next_s.op_valid = 1'b1;
                end else if (roff == tfd_pkg::OFF_MIRROR) begin
                    next_s.host_control = data_i[7:0];
                end
                // Reserved address offset swallows the write, see RL19
            end
        end

        // Push waits for buffer space, so a stalled core loses no word
        if (&next_s.wh && wr_if.ready && !s.push) begin
            next_s.push = 1'b1;
            next_s.wh   = 2'b00;
        end
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s       <= '0;
            s.ack_n <= 1'b1;
        end else begin
            s <= next_s;
        end
    end

    default clocking dflt_cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    mem_window_map_a: assert property ( // see RL8
        !disk_mode_i && !io_mode_i && addr_i[10] && bl && !addr_i[0]
        |-> off == tfd_pkg::OFF_EVEN_COPY && kind != tfd_pkg::K_NONE)
        else $error("window even address not on even data");
    window_word_a: assert property ( // see RL9
        !disk_mode_i && !io_mode_i && addr_i[10] && w
        |-> kind == tfd_pkg::K_WORD)
        else $error("window word access not a data word");
    off1_word_a: assert property ( // see RL16
        !disk_mode_i && w && off == tfd_pkg::OFF_FAULT_INFO
        |-> kind == tfd_pkg::K_WORD)
        else $error("word access at offset 1 missed data");
    dup_fault_hi_a: assert property ( // see RL18
        !disk_mode_i && w && off == tfd_pkg::OFF_FAULT_COPY
        |-> kind == tfd_pkg::K_REG_HI && roff == tfd_pkg::OFF_FAULT_INFO)
        else $error("word at copy offset not fault on high lane");
    byte_fault_a: assert property ( // see RL4
        !disk_mode_i && bh && off == tfd_pkg::OFF_DATA_PORT
        |-> kind == tfd_pkg::K_REG_HI && roff == tfd_pkg::OFF_FAULT_INFO)
        else $error("high lane at offset 0 not fault register");
    narrow_io_a: assert property ( // see RL12
        kind == tfd_pkg::K_REG_HI && io_cyc
        |-> off == tfd_pkg::OFF_DATA_PORT || off == tfd_pkg::OFF_FAULT_COPY)
        else $error("high lane alias used on narrow io cycle");
    disk_mirror_a: assert property ( // see RL11
        disk_mode_i && !control_block_select_n_i && task_file_select_n_i &&
        addr_i[2:0] == 3'h6
        |-> sel && off == tfd_pkg::OFF_MIRROR)
        else $error("control block select missed mirror");
    word_read_a: assert property ( // see RL10
        start && rs && kind == tfd_pkg::K_WORD && rd_if.valid
        |=> data_oe_o == 2'b11 && data_o == $past(rd_if.data)
            && rd_if.ready ##1 !rd_if.ready)
        else $error("word read lanes or pop wrong");
    even_first_a: assert property ( // see RL3
        start && rs && kind == tfd_pkg::K_EVEN_LO && rd_if.valid && !s.rh[1]
        |=> data_o[7:0] == $past(rd_if.data[7:0]) && !rd_if.ready)
        else $error("even byte wrong or popped early");
    disk_width_a: assert property ( // see RL13
        disk_mode_i && start && rs && off == tfd_pkg::OFF_DATA_PORT &&
        !byte_mode_i && rd_if.valid
        |=> data_oe_o == 2'b11)
        else $error("disk data register not 16 bits");
    op_pulse_a: assert property ( // see RL2
        start && ws && kind == tfd_pkg::K_REG_LO &&
        roff == tfd_pkg::OFF_STATE_FLAGS
        |=> op_valid_o && op_issue_o == $past(data_i[7:0]) ##1 !op_valid_o)
        else $error("command write did not pulse once");
    reserved_wr_a: assert property ( // see RL19
        start && ws && roff == tfd_pkg::OFF_UNIT_ADDR
        |=> $stable(host_control_o) && $stable(option_select_o)
            && !op_valid_o && $stable(transfer_block_count_o))
        else $error("reserved write changed state");
endmodule

// ### tfd_pkg.sv
// Purpose: Shared constants and types for the task file decoder.
// Assumes: 16-bit host data bus, 11 host address bits.
// Notes:   Offsets are the four-bit task file offsets seen by the host.
package tfd_pkg;

    localparam int        TFD_DW    = 16;
    localparam int        TFD_AW    = 11;
    localparam int        WIN_BIT   = 10;

    localparam logic [3:0] OFF_DATA_PORT   = 4'h0;
    localparam logic [3:0] OFF_FAULT_INFO  = 4'h1;
    localparam logic [3:0] OFF_BLOCK_COUNT = 4'h2;
    localparam logic [3:0] OFF_START_LOW   = 4'h3;
    localparam logic [3:0] OFF_START_MID   = 4'h4;
    localparam logic [3:0] OFF_START_HIGH  = 4'h5;
    localparam logic [3:0] OFF_UNIT_BITS   = 4'h6;
    localparam logic [3:0] OFF_STATE_FLAGS = 4'h7;
    localparam logic [3:0] OFF_EVEN_COPY   = 4'h8;
    localparam logic [3:0] OFF_ODD_COPY    = 4'h9;
    localparam logic [3:0] OFF_FAULT_COPY  = 4'hD;
    localparam logic [3:0] OFF_MIRROR      = 4'hE;
    localparam logic [3:0] OFF_UNIT_ADDR   = 4'hF;

    // Disk-interface control block sub-address of the mirror register
    localparam logic [2:0] CTL_SUB         = 3'h6;
    localparam logic [7:0] REG_RST         = 8'h00;

    typedef enum logic [2:0] {
        K_NONE,
        K_WORD,
        K_EVEN_LO,
        K_ODD_LO,
        K_ODD_HI,
        K_REG_LO,
        K_REG_HI
    } tfd_kind_t;

    typedef struct packed {
        logic [15:0] dout;
        logic [1:0]  doe;
        logic        act;
        logic [15:0] wbuf;
        logic [1:0]  wh;
        logic        push;
        logic [1:0]  rh;
        logic        pop;
        logic [7:0]  transfer_block_count;
        logic [7:0]  start_block_low;
        logic [7:0]  start_block_mid;
        logic [7:0]  start_block_high;
        logic [7:0]  unit_and_top_bits;
        logic [7:0]  option_select;
        logic [7:0]  op_issue;
        logic        op_valid;
        logic [7:0]  host_control;
        logic        ack_n;
    } tfd_state_t;

endpackage

// ### tfd_skid_buf.sv
// Purpose: Two-entry buffer on a word stream, all outputs registered.
// Assumes: Synchronous active-low reset.
// Notes:   Second entry catches the word in flight when the sink stalls.
`timescale 1ns/1ps
module tfd_skid_buf #(
    parameter int W = 16
) (
    input  wire logic   clk_i,
    input  wire logic   rst_n_i,
    tfd_stream_if.snk   up,
    tfd_stream_if.src   dn
);
    typedef struct packed {
        logic [W-1:0] out_data;
        logic         out_valid;
        logic [W-1:0] skid_data;
        logic         skid_valid;
        logic         in_ready;
    } tfd_buf_t;

    tfd_buf_t s;
    tfd_buf_t next_s;

    if (W < 1) begin : g_chk
        $error("tfd_skid_buf: width must be at least one");
    end

    assign up.ready = s.in_ready;
    assign dn.valid = s.out_valid;
    assign dn.data  = s.out_data;

    always_comb begin
        next_s = s;
        if (dn.ready || !s.out_valid) begin
            if (s.skid_valid) begin
                next_s.out_data   = s.skid_data;
                next_s.out_valid  = 1'b1;
                next_s.skid_valid = 1'b0;
            end else begin
                next_s.out_data  = up.data;
                next_s.out_valid = up.valid;
            end
        end else if (up.valid && !s.skid_valid) begin
            next_s.skid_data  = up.data;
            next_s.skid_valid = 1'b1;
        end
        next_s.in_ready = !next_s.skid_valid;
    end

    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            s          <= '0;
            s.in_ready <= 1'b1;
        end else begin
            s <= next_s;
        end
    end
endmodule

// ### tfd_stream_if.sv
// Purpose: Valid/ready word stream between decoder and its buffers.
// Assumes: Single clock domain.
// Notes:   A word moves on a clock edge with valid and ready both high.
`timescale 1ns/1ps
interface tfd_stream_if #(parameter int W = 16);
    logic         valid;
    logic         ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface
